// ===== logic/elc_pkg.sv
// Package with constants and carrier types for the enclave life-cycle control block
// Behaviour
// - Exactly one control record per enclave instance.
// - Control record used internally; direct software read or write is refused.
// - Create operation allocates a new control record.
// - Create operation sets build measurement to its initial value.
// - Add-page and extend operations fold into build measurement.
// - After init operation the measurement is frozen.
// - Every enclave needs at least one thread record.
// - Entry and exit save and restore per-thread state in its record.
// - Thread flags access only allowed for debug enclaves.
// - Debug step opt-in bit permits single-stepping into that thread.
// - Thread records created by add-page or second-set dynamic operations.
// - Enter into initialized enclave transfers control to enclave code.
// - Exit returns control to the untrusted caller.
// - Successful remove marks the page free for reuse.
// - Linear range is a reservation; pages attach only on commit.
// - Outside software is denied access to enclave pages.
// - With second set, pages may be added to a running enclave.
// - Pages are 4KB units aligned on 4KB boundaries.
package elc_pkg;
   localparam int ENC_N = 4;
   localparam int ENC_W = 2;
   localparam int PAGE_N = 16;
   localparam int PAGE_W = 4;
   localparam int ADDR_W = 32;
   localparam int PAGE_SHIFT = 12;
   localparam int MEAS_W = 32;
   localparam int TSTATE_W = 32;
   localparam logic [MEAS_W-1:0] MEAS_INIT = 32'h6A09E667;
   localparam logic [MEAS_W-1:0] MEAS_MUL = 32'h01000193;
   localparam logic [ADDR_W-1:0] PAGE_OFS_MASK = 32'h00000FFF;
   localparam int FLAG_STEP_BIT = 0;
   localparam int FLAGS_W = 8;

   typedef enum logic [3:0] {
      ELC_OP_CREATE,
      ELC_OP_ADD,
      ELC_OP_EXTEND,
      ELC_OP_INIT,
      ELC_OP_ENTER,
      ELC_OP_EXIT,
      ELC_OP_REMOVE,
      ELC_OP_AUG,
      ELC_OP_FLAGS_RD,
      ELC_OP_FLAGS_WR,
      ELC_OP_ACCESS,
      ELC_OP_RECORD_RD
   } elc_op_t;

   typedef enum logic [2:0] {
      ELC_PT_FREE,
      ELC_PT_CONTROL,
      ELC_PT_THREAD,
      ELC_PT_REG
   } elc_ptype_t;

   typedef enum logic [3:0] {
      ELC_OK,
      ELC_ERR_NO_SPACE,
      ELC_ERR_BAD_ENCLAVE,
      ELC_ERR_LOCKED,
      ELC_ERR_NOT_INIT,
      ELC_ERR_NO_THREAD,
      ELC_ERR_ALIGN,
      ELC_ERR_RANGE,
      ELC_ERR_DENIED,
      ELC_ERR_BAD_PAGE,
      ELC_ERR_NO_EXT2,
      ELC_ERR_BUSY
   } elc_status_t;

   typedef struct packed {
      elc_op_t op;
      logic [ENC_W-1:0] enc;
      logic [PAGE_W-1:0] page;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] size;
      logic [MEAS_W-1:0] data;
      logic thread;
      logic debug;
      logic in_enclave;
      logic [ENC_W-1:0] cur_enc;
   } elc_req_t;

   typedef struct packed {
      elc_status_t status;
      logic [ENC_W-1:0] enc;
      logic [MEAS_W-1:0] data;
      logic [ADDR_W-1:0] target;
      logic in_enclave;
      logic step_ok;
   } elc_rsp_t;
endpackage

// ===== logic/elc_meas_fold.sv
// Measurement fold step used for add-page and extend operations
`timescale 1ns/1ns
module elc_meas_fold
   import elc_pkg::*;
(
   input wire logic [elc_pkg::MEAS_W-1:0] i_meas,
   input wire logic [elc_pkg::MEAS_W-1:0] i_data,
   input wire logic [3:0] i_kind,
   output logic [elc_pkg::MEAS_W-1:0] o_meas
);
   import elc_pkg::*;
   logic [2*MEAS_W-1:0] prod;

   // Multiply-xor fold, kind mixed in so add and extend differ
   always_comb
   begin
      prod = {32'h00000000, i_meas ^ i_data ^ {28'h0000000, i_kind}} * {32'h00000000, MEAS_MUL};
      o_meas = prod[MEAS_W-1:0] ^ {i_meas[15:0], i_meas[31:16]};
   end
endmodule

// ===== logic/elc_top.sv
// Enclave life-cycle control: records, measurement, threads, pages, access checks
`timescale 1ns/1ns
module elc_top
   import elc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ext2_en,
   input wire logic i_req_valid,
   input wire elc_pkg::elc_req_t i_req,
   output logic o_rsp_valid,
   output elc_pkg::elc_rsp_t o_rsp
);
   import elc_pkg::*;

   // Per-enclave control record, never visible to software
   logic [ENC_N-1:0] enc_valid;
   logic [ENC_N-1:0] enc_locked;
   logic [ENC_N-1:0] enc_debug;
   logic [MEAS_W-1:0] enc_meas [ENC_N];
   logic [ADDR_W-1:0] enc_base [ENC_N];
   logic [ADDR_W-1:0] enc_size [ENC_N];
   logic [3:0] enc_threads [ENC_N];

   // Page map
   elc_ptype_t pg_type [PAGE_N];
   logic [ENC_W-1:0] pg_owner [PAGE_N];
   logic [ADDR_W-1:0] pg_lin [PAGE_N];
   logic [FLAGS_W-1:0] pg_flags [PAGE_N];
   logic [TSTATE_W-1:0] pg_tstate [PAGE_N];
   logic [PAGE_W-1:0] pg_busy_thr;
   logic [PAGE_N-1:0] pg_busy;

   // Decode helpers
   logic [ENC_W-1:0] free_enc;
   logic have_free_enc;
   logic [PAGE_N-1:0] free_vec;
   logic aligned;
   logic in_range;
   logic [MEAS_W-1:0] folded;
   elc_status_t next_status;
   logic [ENC_W-1:0] e;
   logic [PAGE_W-1:0] p;

   assign e = i_req.enc;
   assign p = i_req.page;

   // Free page view, one entry per page
   genvar gi;
   generate
      for (gi = 0; gi < PAGE_N; gi++)
      begin : g_free
         assign free_vec[gi] = (pg_type[gi] == ELC_PT_FREE);
      end
   endgenerate

   // First unused enclave slot
   always_comb
   begin
      free_enc = '0;
      have_free_enc = 1'b0;
      for (int k = ENC_N - 1; k >= 0; k--)
      begin
         if (!enc_valid[k])
         begin
            free_enc = k[ENC_W-1:0];
            have_free_enc = 1'b1;
         end
      end
   end

   // Address checks on the 4KB page grid
   assign aligned = ((i_req.addr & PAGE_OFS_MASK) == 32'h00000000);
   assign in_range = (i_req.addr >= enc_base[e]) && ((i_req.addr - enc_base[e]) < enc_size[e]);

   elc_meas_fold u_fold (
      .i_meas(enc_meas[e]),
      .i_data(i_req.op == ELC_OP_ADD ? i_req.addr : i_req.data),
      .i_kind(i_req.op),
      .o_meas(folded)
   );

   // Legality of each operation
   always_comb
   begin
      next_status = ELC_OK;
      case (i_req.op)
         ELC_OP_CREATE:
         begin
            if (!have_free_enc || !free_vec[p])
               next_status = ELC_ERR_NO_SPACE;
            else if (((i_req.addr | i_req.size) & PAGE_OFS_MASK) != 32'h00000000)
               next_status = ELC_ERR_ALIGN;
         end
         ELC_OP_ADD, ELC_OP_AUG:
         begin
            if (!enc_valid[e])
               next_status = ELC_ERR_BAD_ENCLAVE;
            else if (i_req.op == ELC_OP_ADD && enc_locked[e])
               next_status = ELC_ERR_LOCKED;
            else if (i_req.op == ELC_OP_AUG && !i_ext2_en)
               next_status = ELC_ERR_NO_EXT2;
            else if (i_req.op == ELC_OP_AUG && !enc_locked[e])
               next_status = ELC_ERR_NOT_INIT;
            else if (!free_vec[p])
               next_status = ELC_ERR_NO_SPACE;
            else if (!aligned)
               next_status = ELC_ERR_ALIGN;
            else if (!in_range)
               next_status = ELC_ERR_RANGE;
         end
         ELC_OP_EXTEND:
         begin
            if (!enc_valid[e])
               next_status = ELC_ERR_BAD_ENCLAVE;
            else if (enc_locked[e])
               next_status = ELC_ERR_LOCKED;
         end
         ELC_OP_INIT:
         begin
            if (!enc_valid[e])
               next_status = ELC_ERR_BAD_ENCLAVE;
            else if (enc_locked[e])
               next_status = ELC_ERR_LOCKED;
            else if (enc_threads[e] == 4'h0)
               next_status = ELC_ERR_NO_THREAD;
         end
         ELC_OP_ENTER:
         begin
            if (!enc_valid[e] || pg_owner[p] != e)
               next_status = ELC_ERR_BAD_ENCLAVE;
            else if (!enc_locked[e])
               next_status = ELC_ERR_NOT_INIT;
            else if (pg_type[p] != ELC_PT_THREAD)
               next_status = ELC_ERR_BAD_PAGE;
            else if (pg_busy[p] || i_req.in_enclave)
               next_status = ELC_ERR_BUSY;
         end
         ELC_OP_EXIT:
         begin
            if (!i_req.in_enclave || !pg_busy[pg_busy_thr])
               next_status = ELC_ERR_DENIED;
         end
         ELC_OP_REMOVE:
         begin
            if (pg_type[p] == ELC_PT_FREE)
               next_status = ELC_ERR_BAD_PAGE;
            else if (pg_busy[p])
               next_status = ELC_ERR_BUSY;
            else if (pg_type[p] == ELC_PT_CONTROL && enc_threads[pg_owner[p]] != 4'h0)
               next_status = ELC_ERR_BUSY;
         end
         ELC_OP_FLAGS_RD, ELC_OP_FLAGS_WR:
         begin
            if (pg_type[p] != ELC_PT_THREAD)
               next_status = ELC_ERR_BAD_PAGE;
            else if (!enc_debug[pg_owner[p]])
               next_status = ELC_ERR_DENIED;
         end
         ELC_OP_ACCESS:
         begin
            if (pg_type[p] == ELC_PT_FREE)
               next_status = ELC_ERR_BAD_PAGE;
            else if (pg_type[p] != ELC_PT_REG || !i_req.in_enclave || i_req.cur_enc != pg_owner[p])
               next_status = ELC_ERR_DENIED;
         end
         ELC_OP_RECORD_RD:
            next_status = ELC_ERR_DENIED;
         default:
            next_status = ELC_ERR_DENIED;
      endcase
   end

   // Control record table
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         enc_valid <= '0;
         enc_locked <= '0;
         enc_debug <= '0;
         for (int k = 0; k < ENC_N; k++)
         begin
            enc_meas[k] <= '0;
            enc_base[k] <= '0;
            enc_size[k] <= '0;
            enc_threads[k] <= '0;
         end
      end
      else if (i_req_valid && next_status == ELC_OK)
      begin
         case (i_req.op)
            ELC_OP_CREATE:
            begin
               enc_valid[free_enc] <= 1'b1;
               enc_locked[free_enc] <= 1'b0;
               enc_debug[free_enc] <= i_req.debug;
               enc_meas[free_enc] <= MEAS_INIT;
               enc_base[free_enc] <= i_req.addr;
               enc_size[free_enc] <= i_req.size;
               enc_threads[free_enc] <= 4'h0;
            end
            ELC_OP_ADD, ELC_OP_EXTEND:
            begin
               enc_meas[e] <= folded;
               if (i_req.op == ELC_OP_ADD && i_req.thread)
                  enc_threads[e] <= enc_threads[e] + 4'h1;
            end
            ELC_OP_AUG:
               if (i_req.thread)
                  enc_threads[e] <= enc_threads[e] + 4'h1;
            ELC_OP_INIT:
               enc_locked[e] <= 1'b1;
            ELC_OP_REMOVE:
            begin
               if (pg_type[p] == ELC_PT_CONTROL)
                  enc_valid[pg_owner[p]] <= 1'b0;
               else if (pg_type[p] == ELC_PT_THREAD)
                  enc_threads[pg_owner[p]] <= enc_threads[pg_owner[p]] - 4'h1;
            end
            default: ;
         endcase
      end
   end

   // Page map updates
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         for (int k = 0; k < PAGE_N; k++)
         begin
            pg_type[k] <= ELC_PT_FREE;
            pg_owner[k] <= '0;
            pg_lin[k] <= '0;
            pg_flags[k] <= '0;
         end
      end
      else if (i_req_valid && next_status == ELC_OK)
      begin
         case (i_req.op)
            ELC_OP_CREATE:
            begin
               pg_type[p] <= ELC_PT_CONTROL;
               pg_owner[p] <= free_enc;
            end
            ELC_OP_ADD, ELC_OP_AUG:
            begin
               pg_type[p] <= i_req.thread ? ELC_PT_THREAD : ELC_PT_REG;
               pg_owner[p] <= e;
               pg_lin[p] <= i_req.addr;
               pg_flags[p] <= '0;
            end
            ELC_OP_REMOVE:
               pg_type[p] <= ELC_PT_FREE;
            ELC_OP_FLAGS_WR:
               pg_flags[p] <= i_req.data[FLAGS_W-1:0];
            default: ;
         endcase
      end
   end

   // Thread state save and restore across entry and exit
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pg_busy <= '0;
         pg_busy_thr <= '0;
         for (int k = 0; k < PAGE_N; k++)
            pg_tstate[k] <= '0;
      end
      else if (i_req_valid && next_status == ELC_OK)
      begin
         if (i_req.op == ELC_OP_ENTER)
         begin
            pg_busy[p] <= 1'b1;
            pg_busy_thr <= p;
         end
         else if (i_req.op == ELC_OP_EXIT)
         begin
            pg_busy[pg_busy_thr] <= 1'b0;
            pg_tstate[pg_busy_thr] <= i_req.data;
         end
      end
   end

   // Registered answer
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_rsp_valid <= 1'b0;
         o_rsp <= '0;
      end
      else
      begin
         o_rsp_valid <= i_req_valid;
         o_rsp.status <= next_status;
         o_rsp.enc <= (i_req.op == ELC_OP_CREATE) ? free_enc : e;
         o_rsp.data <= '0;
         o_rsp.target <= '0;
         o_rsp.in_enclave <= i_req.in_enclave;
         o_rsp.step_ok <= 1'b0;
         if (i_req_valid && next_status == ELC_OK)
         begin
            case (i_req.op)
               ELC_OP_ENTER:
               begin
                  o_rsp.in_enclave <= 1'b1;
                  o_rsp.target <= pg_lin[p];
                  o_rsp.data <= pg_tstate[p];
                  o_rsp.step_ok <= enc_debug[e] && pg_flags[p][FLAG_STEP_BIT];
               end
               ELC_OP_EXIT:
               begin
                  o_rsp.in_enclave <= 1'b0;
                  o_rsp.target <= i_req.addr;
               end
               ELC_OP_FLAGS_RD:
                  o_rsp.data <= {24'h000000, pg_flags[p]};
               default:
               begin
               end
            endcase
         end
      end
   end

   // Assertions
   a_meas_locked_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      (enc_locked[e] && i_req_valid && i_req.op != ELC_OP_CREATE) |=> enc_meas[$past(e)] == $past(enc_meas[e]))
      else $error("measurement changed after lock");
   a_add_locked_rej: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req_valid && enc_valid[e] && enc_locked[e] && (i_req.op == ELC_OP_ADD || i_req.op == ELC_OP_EXTEND))
      |=> o_rsp_valid && o_rsp.status == ELC_ERR_LOCKED)
      else $error("add or extend on locked enclave not rejected");
   a_record_rd_deny: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req_valid && i_req.op == ELC_OP_RECORD_RD) |=> o_rsp.status == ELC_ERR_DENIED && o_rsp.data == '0)
      else $error("control record read not refused");
   a_init_needs_thr: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req_valid && i_req.op == ELC_OP_INIT && !enc_locked[e] && enc_threads[e] == 4'h0) |=> !enc_locked[$past(e)])
      else $error("enclave locked without thread record");
   a_create_meas_init: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req_valid && i_req.op == ELC_OP_CREATE && next_status == ELC_OK)
      |=> enc_meas[$past(free_enc)] == MEAS_INIT && enc_valid[$past(free_enc)])
      else $error("create did not set initial measurement");
   a_remove_frees: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req_valid && i_req.op == ELC_OP_REMOVE && next_status == ELC_OK) |=> pg_type[$past(p)] == ELC_PT_FREE)
      else $error("removed page not free");
   a_flags_debug_only: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req_valid && i_req.op == ELC_OP_FLAGS_WR && !enc_debug[pg_owner[p]])
      |=> pg_flags[$past(p)] == $past(pg_flags[p]) && o_rsp.status != ELC_OK)
      else $error("thread flags reached on non-debug enclave");
   a_enter_needs_init: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_rsp_valid && o_rsp.in_enclave && $past(i_req.op) == ELC_OP_ENTER && o_rsp.status == ELC_OK)
      |-> $past(enc_locked[i_req.enc]))
      else $error("entry into uninitialized enclave");
   a_outside_denied: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req_valid && i_req.op == ELC_OP_ACCESS && !i_req.in_enclave) |=> o_rsp.status != ELC_OK)
      else $error("outside software reached enclave page");
   a_aug_needs_ext2: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_req_valid && i_req.op == ELC_OP_AUG && enc_valid[e] && !i_ext2_en) |=> o_rsp.status == ELC_ERR_NO_EXT2)
      else $error("dynamic add without second set");
endmodule

// ===== bench/elc_sw_model.sv
// Software-side model that issues enclave operations and collects the answers
`timescale 1ns/1ns
module elc_sw_model
   import elc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rsp_valid,
   input wire elc_pkg::elc_rsp_t i_rsp,
   output logic o_req_valid,
   output elc_pkg::elc_req_t o_req
);
   // Idle request lines at time zero
   initial
   begin
      o_req_valid = 1'b0;
      o_req = '0;
   end

   // One-cycle request pulse; the answer stands from the taking edge to the next one, read mid-cycle
   task automatic issue(input elc_req_t r, output elc_rsp_t s, output logic ok);
   begin
      @(negedge i_clk);
      o_req_valid = 1'b1;
      o_req = r;
      @(negedge i_clk);
      ok = i_rsp_valid;
      s = i_rsp;
      o_req_valid = 1'b0;
      o_req = elc_req_t'(~r); // Released fields stop showing the last request
   end
   endtask
endmodule

// ===== bench/elc_top_tb_top.sv
// Self-checking testbench for the enclave life-cycle control block
`timescale 1ns/1ns
module elc_top_tb_top;
   import elc_pkg::*;
   localparam logic [31:0] BASE = 32'h00010000;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic ext2 = 1'b0;
   logic req_valid;
   elc_req_t req;
   logic rsp_valid;
   elc_rsp_t rsp;
   elc_rsp_t r;
   logic [ENC_W-1:0] e0;
   logic [ENC_W-1:0] e1;
   logic [ENC_W-1:0] ed;
   int fails = 0;
   int compares = 0;
   int cycles = 0;

   elc_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_ext2_en(ext2), .i_req_valid(req_valid), .i_req(req),
      .o_rsp_valid(rsp_valid), .o_rsp(rsp));
   elc_sw_model sw (.i_clk(i_clk), .i_rsp_valid(rsp_valid), .i_rsp(rsp), .o_req_valid(req_valid),
      .o_req(req));

   // Clock at 100 ns period
   always #50 i_clk = ~i_clk;

   // Hang guard
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fails++;
         close_out();
      end
   end

   task automatic close_out();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk_st(string nm, elc_status_t e, elc_status_t g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic chk_w(string nm, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic chk_b(string nm, logic e, logic g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %0b seen %0b", nm, e, g);
      end
   endtask

   // Builds one request; the caller's enclave is the target enclave
   function automatic elc_req_t mk(elc_op_t op, logic [ENC_W-1:0] e, logic [PAGE_W-1:0] p,
      logic [31:0] a, logic [31:0] d, logic th, logic dbg, logic in);
      elc_req_t q;
      q = '0;
      q.op = op;
      q.enc = e;
      q.page = p;
      q.addr = a;
      q.size = 32'h00004000;
      q.data = d;
      q.thread = th;
      q.debug = dbg;
      q.in_enclave = in;
      q.cur_enc = e;
      return q;
   endfunction

   // Issues one request and checks that it is answered with the expected status
   task automatic run(elc_req_t q, elc_status_t exp, string nm);
      logic ok;
      sw.issue(q, r, ok);
      chk_b({nm, " answer"}, 1'b1, ok);
      chk_st(nm, exp, r.status);
   endtask

   task automatic t_create();
      run(mk(ELC_OP_CREATE, 2'h0, 4'h0, BASE, 0, 0, 0, 0), ELC_OK, "create");
      e0 = r.enc;
      run(mk(ELC_OP_CREATE, 2'h0, 4'h0, BASE, 0, 0, 0, 0), ELC_ERR_NO_SPACE, "create on used page");
      run(mk(ELC_OP_CREATE, 2'h0, 4'h3, BASE + 32'h800, 0, 0, 0, 0), ELC_ERR_ALIGN, "create unaligned");
      run(mk(ELC_OP_CREATE, 2'h0, 4'h3, 32'h00020000, 0, 0, 0, 0), ELC_OK, "create second");
      e1 = r.enc;
      chk_b("distinct record", 1'b1, e1 !== e0);
      $display("test create done");
   endtask

   task automatic t_build();
      run(mk(ELC_OP_ADD, e0, 4'h1, BASE, 0, 1, 0, 0), ELC_OK, "add thread");
      run(mk(ELC_OP_EXTEND, e0, 4'h1, BASE, 32'h12345678, 0, 0, 0), ELC_OK, "extend");
      run(mk(ELC_OP_ADD, e0, 4'h2, BASE + 32'h1000, 0, 0, 0, 0), ELC_OK, "add page");
      run(mk(ELC_OP_ADD, e0, 4'h7, BASE + 32'h4000, 0, 0, 0, 0), ELC_ERR_RANGE, "add outside");
      run(mk(ELC_OP_ADD, e0, 4'h7, BASE + 32'h1010, 0, 0, 0, 0), ELC_ERR_ALIGN, "add unaligned");
      run(mk(ELC_OP_INIT, e1, 4'h0, 0, 0, 0, 0, 0), ELC_ERR_NO_THREAD, "init no thread");
      run(mk(ELC_OP_INIT, e0, 4'h0, 0, 0, 0, 0, 0), ELC_OK, "init");
      run(mk(ELC_OP_EXTEND, e0, 4'h1, BASE, 1, 0, 0, 0), ELC_ERR_LOCKED, "extend locked");
      run(mk(ELC_OP_ADD, e0, 4'h7, BASE + 32'h3000, 0, 0, 0, 0), ELC_ERR_LOCKED, "add locked");
      run(mk(ELC_OP_RECORD_RD, e0, 4'h0, 0, 0, 0, 0, 0), ELC_ERR_DENIED, "record read");
      chk_w("record data", 32'h00000000, r.data);
      $display("test build done");
   endtask

   task automatic t_enter();
      run(mk(ELC_OP_ENTER, e0, 4'h1, 0, 0, 0, 0, 0), ELC_OK, "enter");
      chk_b("enter inside", 1'b1, r.in_enclave);
      chk_w("enter target", BASE, r.target);
      chk_b("step on plain enclave", 1'b0, r.step_ok);
      run(mk(ELC_OP_EXIT, e0, 4'h1, 32'h00005000, 32'hA5A5A5A5, 0, 0, 1), ELC_OK, "exit");
      chk_b("exit outside", 1'b0, r.in_enclave);
      chk_w("exit target", 32'h00005000, r.target);
      run(mk(ELC_OP_EXIT, e0, 4'h1, 32'h00005000, 0, 0, 0, 0), ELC_ERR_DENIED, "exit not inside");
      run(mk(ELC_OP_ENTER, e0, 4'h1, 0, 0, 0, 0, 0), ELC_OK, "enter again");
      chk_w("saved state", 32'hA5A5A5A5, r.data);
      run(mk(ELC_OP_ACCESS, e0, 4'h2, BASE + 32'h1000, 0, 0, 0, 1), ELC_OK, "inside access");
      run(mk(ELC_OP_EXIT, e0, 4'h1, 32'h00006000, 0, 0, 0, 1), ELC_OK, "exit again");
      run(mk(ELC_OP_ACCESS, e0, 4'h2, BASE + 32'h1000, 0, 0, 0, 0), ELC_ERR_DENIED, "outside access");
      run(mk(ELC_OP_FLAGS_RD, e0, 4'h1, 0, 0, 0, 0, 0), ELC_ERR_DENIED, "flags plain");
      run(mk(ELC_OP_FLAGS_WR, e0, 4'h1, 0, 32'h00000001, 0, 0, 0), ELC_ERR_DENIED, "flags write plain");
      $display("test enter done");
   endtask

   task automatic t_debug();
      run(mk(ELC_OP_CREATE, 2'h0, 4'h4, 32'h00030000, 0, 0, 1, 0), ELC_OK, "create debug");
      ed = r.enc;
      run(mk(ELC_OP_ADD, ed, 4'h5, 32'h00030000, 0, 1, 1, 0), ELC_OK, "add debug thread");
      run(mk(ELC_OP_INIT, ed, 4'h4, 0, 0, 0, 1, 0), ELC_OK, "init debug");
      run(mk(ELC_OP_FLAGS_WR, ed, 4'h5, 0, 32'h00000001, 0, 1, 0), ELC_OK, "flags write");
      run(mk(ELC_OP_FLAGS_RD, ed, 4'h5, 0, 0, 0, 1, 0), ELC_OK, "flags read");
      chk_w("flags value", 32'h00000001, r.data);
      run(mk(ELC_OP_ENTER, ed, 4'h5, 0, 0, 0, 1, 0), ELC_OK, "enter debug");
      chk_b("step opted in", 1'b1, r.step_ok);
      run(mk(ELC_OP_EXIT, ed, 4'h5, 32'h00007000, 0, 0, 1, 1), ELC_OK, "exit debug");
      $display("test debug done");
   endtask

   task automatic t_aug();
      run(mk(ELC_OP_AUG, e0, 4'h6, BASE + 32'h2000, 0, 0, 0, 0), ELC_ERR_NO_EXT2, "aug unsupported");
      @(negedge i_clk);
      ext2 = 1'b1;
      run(mk(ELC_OP_AUG, e0, 4'h6, BASE + 32'h2000, 0, 0, 0, 0), ELC_OK, "aug running");
      run(mk(ELC_OP_AUG, e1, 4'h7, 32'h00020000, 0, 0, 0, 0), ELC_ERR_NOT_INIT, "aug unbuilt");
      $display("test aug done");
   endtask

   // Teardown removes every page of enclave e0, control page last
   task automatic t_remove();
      run(mk(ELC_OP_REMOVE, e0, 4'h0, 0, 0, 0, 0, 0), ELC_ERR_BUSY, "remove control early");
      run(mk(ELC_OP_REMOVE, e0, 4'h1, 0, 0, 0, 0, 0), ELC_OK, "remove thread");
      run(mk(ELC_OP_REMOVE, e0, 4'h2, 0, 0, 0, 0, 0), ELC_OK, "remove page");
      run(mk(ELC_OP_REMOVE, e0, 4'h6, 0, 0, 0, 0, 0), ELC_OK, "remove aug page");
      run(mk(ELC_OP_REMOVE, e0, 4'h0, 0, 0, 0, 0, 0), ELC_OK, "remove control");
      run(mk(ELC_OP_CREATE, 2'h0, 4'h1, 32'h00040000, 0, 0, 0, 0), ELC_OK, "reuse freed page");
      $display("test remove done");
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(negedge i_clk);
      i_rst = 1'b0;
      t_create();
      t_build();
      t_enter();
      t_debug();
      t_aug();
      t_remove();
      close_out();
   end
endmodule
